// ---- include/tx_state_pkg.sv ----
package tx_state_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_RX_FREE_BUFFER_COUNT_CH3 = 8'h00;
	localparam logic [7:0] OFS_TX_STATE_QUEUE_HEAD = 8'h04;
	localparam logic [7:0] OFS_TX_STATE_PACKET_START = 8'h08;
	localparam logic [7:0] OFS_TX_STATE_CURRENT_DESCRIPTOR = 8'h0c;
	localparam logic [7:0] OFS_TX_STATE_CURRENT_BUFFER_ADDRESS = 8'h10;

	// field layout
	localparam int FREE_BUFFER_TALLY_W = 16;
	localparam int PTR_LSB = 2;
	localparam int PTR_W = 30;
	localparam int IN_PACKET_BIT = 0;
	localparam int EARLY_TRUNCATION_BIT = 1;

	// reset values
	localparam logic [15:0] RST_FREE_BUFFER_TALLY = 16'h0000;
	localparam logic [29:0] RST_PTR = 30'h00000000;
	localparam logic [31:0] RST_BUFFER_ADDRESS = 32'h00000000;

	// least number of queued receive buffers the receive DMA needs
	localparam logic [15:0] RX_MIN_BUFFERS = 16'h0003;

	typedef enum logic {
		PHASE_IDLE,
		PHASE_IN_PACKET
	} tx_phase_t;

endpackage

// ---- src/rx_free_counter.sv ----
`timescale 1ns/10ps
`default_nettype none

module rx_free_counter #(
	parameter int WIDTH = 16
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_sync_n,
	input wire logic ce,
	// software increment
	input wire logic add_en,
	input wire logic [WIDTH-1:0] add_value,
	// receive DMA consumed one buffer
	input wire logic take,
	// state
	output logic [WIDTH-1:0] count_reg,
	output logic short_reg
);

	logic [WIDTH-1:0] count_next;
	logic short_next;
	logic [WIDTH-1:0] sum;

	always_comb
	begin
		sum = count_reg;
		if (add_en)
			sum = count_reg + add_value;
		count_next = sum;
		if (take && (sum != '0))
			count_next = sum - WIDTH'(1);
		short_next = (count_next < WIDTH'(tx_state_pkg::RX_MIN_BUFFERS));
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			count_reg <= WIDTH'(tx_state_pkg::RST_FREE_BUFFER_TALLY);
			short_reg <= 1'b1;
		end
		else if (ce)
		begin
			count_reg <= count_next;
			short_reg <= short_next;
		end
	end

endmodule

`default_nettype wire

// ---- src/usb_dma_tx_state_words.sv ----
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - A software write to the receive buffer tally adds to it, never overwrites.
// - The tally reports free receive buffers queued for receive channel 3.
// - Word 0 bits 31..2 hold the high-priority transmit queue head pointer.
// - Words 0 and 1 bit 0 read 1 while a packet is in progress.
// - Word 1 bits 31..2 point to the first descriptor of the current packet.
// - Word 2 bits 31..2 point to the descriptor of the buffer now sent.
// - Word 2 bit 1 sets when truncation happens inside a non-final buffer.
// - Word 3 holds the absolute byte address being fetched in the buffer.
module usb_dma_tx_state_words #(
	parameter int ADDR_W = 8
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// receive DMA events
	input wire logic rx_buffer_taken,
	// transmit DMA events
	input wire logic tx_desc_load,
	input wire logic [31:0] tx_desc_addr,
	input wire logic tx_desc_sop,
	input wire logic tx_desc_eop,
	input wire logic [31:0] tx_desc_buf_addr,
	input wire logic tx_fetch_advance,
	input wire logic [15:0] tx_fetch_bytes,
	input wire logic tx_truncate,
	input wire logic tx_buffer_done,
	input wire logic [31:0] tx_next_head,
	// state seen by the DMA
	output logic [15:0] free_buffer_tally,
	output logic rx_buffers_short,
	output logic tx_in_packet,
	output logic tx_early_truncation,
	output logic [31:0] active_buffer_byte_address,
	output logic [31:0] active_descriptor_pointer
);

	function automatic logic [29:0] ptr_of(input logic [31:0] word);
		ptr_of = word[31:2];
	endfunction

	function automatic logic [31:0] word_of(input logic [29:0] ptr,
		input logic bit1, input logic bit0);
		word_of = {ptr, bit1, bit0};
	endfunction

	// reset release synchroniser
	logic rst_meta_reg;
	logic rst_sync_reg;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// address decode
	logic wr_count;
	logic wr_head;
	logic wr_start;
	logic wr_desc;
	logic wr_buf;

	always_comb
	begin
		wr_count = reg_wr &&
			(reg_addr == ADDR_W'(tx_state_pkg::OFS_RX_FREE_BUFFER_COUNT_CH3));
		wr_head = reg_wr &&
			(reg_addr == ADDR_W'(tx_state_pkg::OFS_TX_STATE_QUEUE_HEAD));
		wr_start = reg_wr &&
			(reg_addr == ADDR_W'(tx_state_pkg::OFS_TX_STATE_PACKET_START));
		wr_desc = reg_wr && (reg_addr ==
			ADDR_W'(tx_state_pkg::OFS_TX_STATE_CURRENT_DESCRIPTOR));
		wr_buf = reg_wr && (reg_addr ==
			ADDR_W'(tx_state_pkg::OFS_TX_STATE_CURRENT_BUFFER_ADDRESS));
	end

	// receive buffer tally
	logic [15:0] tally;
	logic short_flag;

	rx_free_counter #(
		.WIDTH(tx_state_pkg::FREE_BUFFER_TALLY_W)
	) u_rx_free_counter (
		.clk_sys(clk_sys),
		.rst_sync_n(rst_sync_reg),
		.ce(ce),
		.add_en(wr_count),
		.add_value(reg_wdata[15:0]),
		.take(rx_buffer_taken),
		.count_reg(tally),
		.short_reg(short_flag)
	);

	// transmit state
	logic [29:0] head_ptr_reg;
	logic [29:0] head_ptr_next;
	logic [29:0] start_ptr_reg;
	logic [29:0] start_ptr_next;
	logic [29:0] desc_ptr_reg;
	logic [29:0] desc_ptr_next;
	logic [31:0] buf_addr_reg;
	logic [31:0] buf_addr_next;
	logic trunc_reg;
	logic trunc_next;
	logic cur_eop_reg;
	logic cur_eop_next;
	tx_state_pkg::tx_phase_t phase_reg;
	tx_state_pkg::tx_phase_t phase_next;

	// software writes land first, DMA events then override them,
	// so a hardware update in the same cycle is never lost to a software write
	always_comb
	begin
		head_ptr_next = head_ptr_reg;
		start_ptr_next = start_ptr_reg;
		desc_ptr_next = desc_ptr_reg;
		buf_addr_next = buf_addr_reg;
		trunc_next = trunc_reg;
		cur_eop_next = cur_eop_reg;
		phase_next = phase_reg;

		if (wr_head)
		begin
			head_ptr_next = ptr_of(reg_wdata);
			phase_next = reg_wdata[tx_state_pkg::IN_PACKET_BIT] ?
				tx_state_pkg::PHASE_IN_PACKET : tx_state_pkg::PHASE_IDLE;
		end
		if (wr_start)
		begin
			start_ptr_next = ptr_of(reg_wdata);
			phase_next = reg_wdata[tx_state_pkg::IN_PACKET_BIT] ?
				tx_state_pkg::PHASE_IN_PACKET : tx_state_pkg::PHASE_IDLE;
		end
		if (wr_desc)
		begin
			desc_ptr_next = ptr_of(reg_wdata);
			trunc_next = reg_wdata[tx_state_pkg::EARLY_TRUNCATION_BIT];
		end
		if (wr_buf)
			buf_addr_next = reg_wdata;

		if (tx_desc_load)
		begin
			desc_ptr_next = ptr_of(tx_desc_addr);
			buf_addr_next = tx_desc_buf_addr;
			cur_eop_next = tx_desc_eop;
			if (tx_desc_sop)
			begin
				start_ptr_next = ptr_of(tx_desc_addr);
				trunc_next = 1'b0;
				phase_next = tx_state_pkg::PHASE_IN_PACKET;
			end
		end
		else if (tx_fetch_advance)
		begin
			buf_addr_next = buf_addr_reg + {16'h0000, tx_fetch_bytes};
		end

		if (tx_truncate && !cur_eop_next)
			trunc_next = 1'b1;

		case (phase_reg)
			tx_state_pkg::PHASE_IDLE:
			begin
				// a stray completion outside a packet changes nothing
			end
			tx_state_pkg::PHASE_IN_PACKET:
			begin
				if (tx_buffer_done && cur_eop_reg && !tx_desc_load)
				begin
					phase_next = tx_state_pkg::PHASE_IDLE;
					trunc_next = 1'b0;
					head_ptr_next = ptr_of(tx_next_head);
				end
			end
			default:
			begin
				phase_next = tx_state_pkg::PHASE_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			head_ptr_reg <= tx_state_pkg::RST_PTR;
			start_ptr_reg <= tx_state_pkg::RST_PTR;
			desc_ptr_reg <= tx_state_pkg::RST_PTR;
			buf_addr_reg <= tx_state_pkg::RST_BUFFER_ADDRESS;
			trunc_reg <= 1'b0;
			cur_eop_reg <= 1'b0;
			phase_reg <= tx_state_pkg::PHASE_IDLE;
		end
		else if (ce)
		begin
			head_ptr_reg <= head_ptr_next;
			start_ptr_reg <= start_ptr_next;
			desc_ptr_reg <= desc_ptr_next;
			buf_addr_reg <= buf_addr_next;
			trunc_reg <= trunc_next;
			cur_eop_reg <= cur_eop_next;
			phase_reg <= phase_next;
		end
	end

	// read path and registered outputs
	logic in_pkt;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [15:0] tally_out_reg;
	logic short_out_reg;
	logic in_pkt_reg;
	logic trunc_out_reg;
	logic [31:0] buf_out_reg;
	logic [31:0] desc_out_reg;

	always_comb
	begin
		in_pkt = (phase_reg == tx_state_pkg::PHASE_IN_PACKET);
		// data stand only in the cycle after the read strobe
		rdata_next = 32'h00000000;
		if (reg_rd)
		begin
			case (reg_addr)
				ADDR_W'(tx_state_pkg::OFS_RX_FREE_BUFFER_COUNT_CH3):
					rdata_next = {16'h0000, tally};
				ADDR_W'(tx_state_pkg::OFS_TX_STATE_QUEUE_HEAD):
					rdata_next = word_of(head_ptr_reg, 1'b0, in_pkt);
				ADDR_W'(tx_state_pkg::OFS_TX_STATE_PACKET_START):
					rdata_next = word_of(start_ptr_reg, 1'b0, in_pkt);
				ADDR_W'(tx_state_pkg::OFS_TX_STATE_CURRENT_DESCRIPTOR):
					rdata_next = word_of(desc_ptr_reg, trunc_reg, 1'b0);
				ADDR_W'(tx_state_pkg::OFS_TX_STATE_CURRENT_BUFFER_ADDRESS):
					rdata_next = buf_addr_reg;
				default:
					rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			rdata_reg <= 32'h00000000;
			tally_out_reg <= tx_state_pkg::RST_FREE_BUFFER_TALLY;
			short_out_reg <= 1'b1;
			in_pkt_reg <= 1'b0;
			trunc_out_reg <= 1'b0;
			buf_out_reg <= tx_state_pkg::RST_BUFFER_ADDRESS;
			desc_out_reg <= 32'h00000000;
		end
		else if (ce)
		begin
			rdata_reg <= rdata_next;
			tally_out_reg <= tally;
			short_out_reg <= short_flag;
			in_pkt_reg <= in_pkt;
			trunc_out_reg <= trunc_reg;
			buf_out_reg <= buf_addr_reg;
			desc_out_reg <= word_of(desc_ptr_reg, 1'b0, 1'b0);
		end
	end

	assign reg_rdata = rdata_reg;
	assign free_buffer_tally = tally_out_reg;
	assign rx_buffers_short = short_out_reg;
	assign tx_in_packet = in_pkt_reg;
	assign tx_early_truncation = trunc_out_reg;
	assign active_buffer_byte_address = buf_out_reg;
	assign active_descriptor_pointer = desc_out_reg;

endmodule

`default_nettype wire

// ---- tb/tx_state_properties.sv ----
`timescale 1ns/10ps
`default_nettype none

module tx_state_checker #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// dma events
	input wire logic rx_buffer_taken,
	input wire logic tx_desc_load,
	input wire logic [31:0] tx_desc_addr,
	input wire logic tx_desc_sop,
	input wire logic [31:0] tx_desc_buf_addr,
	input wire logic tx_fetch_advance,
	input wire logic [15:0] tx_fetch_bytes,
	// state outputs
	input wire logic [15:0] free_buffer_tally,
	input wire logic rx_buffers_short,
	input wire logic tx_in_packet,
	input wire logic [31:0] active_buffer_byte_address,
	input wire logic [31:0] active_descriptor_pointer
);
	default clocking @(posedge clk_sys); endclocking
	// frozen cycles are skipped: all state except the reset synchroniser holds while ce is low
	default disable iff (!rstn || !ce);

	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not idle");
	inpkt_read_a: assert property (reg_rd && reg_addr == 8'h04
		|=> reg_rdata[0] == tx_in_packet && !reg_rdata[1])
		else $error("word 0 flag mismatch");
	sop_load_a: assert property (tx_desc_load && tx_desc_sop
		|=> ##1 tx_in_packet)
		else $error("in packet not set");
	desc_ptr_a: assert property (tx_desc_load |=> ##1
		active_descriptor_pointer == ($past(tx_desc_addr, 2) & 32'hfffffffc))
		else $error("descriptor pointer wrong");
	buf_addr_a: assert property (tx_desc_load |=> ##1
		active_buffer_byte_address == $past(tx_desc_buf_addr, 2))
		else $error("buffer address not loaded");
	fetch_add_a: assert property (tx_fetch_advance && !tx_desc_load
		|=> ##1 active_buffer_byte_address ==
		$past(active_buffer_byte_address) + $past(tx_fetch_bytes, 2))
		else $error("buffer address not advanced");
	tally_add_a: assert property (reg_wr && reg_addr == 8'h00
		&& !rx_buffer_taken |=> ##1 free_buffer_tally ==
		$past(free_buffer_tally) + 16'($past(reg_wdata, 2)))
		else $error("tally not added");
	// both outputs are registered copies taken at the same edge
	short_flag_a: assert property (rx_buffers_short ==
		(free_buffer_tally < tx_state_pkg::RX_MIN_BUFFERS))
		else $error("short flag wrong");

	cover property (tx_desc_load && tx_desc_sop);
	cover property (reg_wr && reg_addr == 8'h00);
	cover property (tx_in_packet ##1 !tx_in_packet);
endmodule

bind usb_dma_tx_state_words tx_state_checker #(.ADDR_W(ADDR_W)) u_chk (
	.clk_sys, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .rx_buffer_taken, .tx_desc_load, .tx_desc_addr, .tx_desc_sop,
	.tx_desc_buf_addr, .tx_fetch_advance, .tx_fetch_bytes,
	.free_buffer_tally, .rx_buffers_short, .tx_in_packet,
	.active_buffer_byte_address, .active_descriptor_pointer);

`default_nettype wire

// ---- tb/tx_queue_partner.sv ----
`timescale 1ns/10ps
`default_nettype none

module tx_queue_partner (
	// clock
	input wire logic clk_sys,
	// descriptor and fetch events
	output logic tx_desc_load,
	output logic [31:0] tx_desc_addr,
	output logic tx_desc_sop,
	output logic tx_desc_eop,
	output logic [31:0] tx_desc_buf_addr,
	output logic tx_fetch_advance,
	output logic [15:0] tx_fetch_bytes,
	output logic tx_truncate,
	output logic tx_buffer_done,
	output logic [31:0] tx_next_head
);
	initial
	begin
		{tx_desc_load, tx_desc_sop, tx_desc_eop} = 3'h0;
		{tx_fetch_advance, tx_truncate, tx_buffer_done} = 3'h0;
		{tx_desc_addr, tx_desc_buf_addr, tx_next_head} = 96'h0;
		tx_fetch_bytes = 16'h0;
	end

	// stall stands for a slow descriptor fetch from memory
	task automatic ld(input logic [31:0] d, input logic [31:0] b,
		input logic sop, input logic eop, input int stall);
	begin
		repeat (stall) @(posedge clk_sys);
		@(posedge clk_sys);
		tx_desc_load <= 1'b1;
		tx_desc_addr <= d;
		tx_desc_buf_addr <= b;
		tx_desc_sop <= sop;
		tx_desc_eop <= eop;
		@(posedge clk_sys);
		// released lines must not keep showing the old value
		tx_desc_load <= 1'b0;
		tx_desc_addr <= ~d;
		tx_desc_buf_addr <= ~b;
		tx_desc_sop <= ~sop;
		tx_desc_eop <= ~eop;
	end
	endtask

	task automatic ev(input logic adv, input logic tr, input logic dn,
		input logic [15:0] n, input logic [31:0] nh);
	begin
		@(posedge clk_sys);
		tx_fetch_advance <= adv;
		tx_truncate <= tr;
		tx_buffer_done <= dn;
		tx_fetch_bytes <= n;
		tx_next_head <= nh;
		@(posedge clk_sys);
		{tx_fetch_advance, tx_truncate, tx_buffer_done} <= 3'h0;
		tx_fetch_bytes <= ~n;
		tx_next_head <= ~nh;
	end
	endtask
endmodule

`default_nettype wire

// ---- tb/usb_dma_tx_state_words_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module usb_dma_tx_state_words_tb_top;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rx_buffer_taken = 1'b0;
	logic [31:0] reg_rdata, active_buffer_byte_address;
	logic [31:0] active_descriptor_pointer, tx_desc_addr;
	logic [31:0] tx_desc_buf_addr, tx_next_head, v, a, b, m;
	logic tx_desc_load, tx_desc_sop, tx_desc_eop, tx_fetch_advance;
	logic tx_truncate, tx_buffer_done, rx_buffers_short;
	logic tx_in_packet, tx_early_truncation;
	logic [15:0] tx_fetch_bytes, free_buffer_tally;
	integer seed, i;
	integer fails = 0;
	integer total_checks = 0;
	integer tally = 0;

	always #20 clk_sys = ~clk_sys;

	usb_dma_tx_state_words #(.ADDR_W(8)) dut (.clk_sys, .rstn, .ce,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_buffer_taken, .tx_desc_load, .tx_desc_addr, .tx_desc_sop,
		.tx_desc_eop, .tx_desc_buf_addr, .tx_fetch_advance, .tx_fetch_bytes,
		.tx_truncate, .tx_buffer_done, .tx_next_head, .free_buffer_tally,
		.rx_buffers_short, .tx_in_packet, .tx_early_truncation,
		.active_buffer_byte_address, .active_descriptor_pointer);

	tx_queue_partner p (.clk_sys, .tx_desc_load, .tx_desc_addr,
		.tx_desc_sop, .tx_desc_eop, .tx_desc_buf_addr, .tx_fetch_advance,
		.tx_fetch_bytes, .tx_truncate, .tx_buffer_done, .tx_next_head);

	task automatic test_done();
	begin
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
	begin
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	end
	endtask

	// read data is only valid in the single cycle after the strobe
	task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
	begin
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	end
	endtask

	task automatic take();
	begin
		@(posedge clk_sys);
		rx_buffer_taken <= 1'b1;
		@(posedge clk_sys);
		rx_buffer_taken <= 1'b0;
	end
	endtask

	initial
	begin
		repeat (3000) @(posedge clk_sys);
		fails++;
		test_done();
	end

	initial
	begin
		seed = 72765;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (i = 0; i < 5; i++)
			rd(8'(i * 4), 32'h0);
		chk(32'(rx_buffers_short), 32'h1);
		for (i = 0; i < 6; i++)
		begin
			v = $random(seed);
			wr(8'h00, v);
			tally = (tally + v[15:0]) % 65536;
			rd(8'h00, 32'(tally));
		end
		// wrapping the sum brings the tally back to zero
		wr(8'h00, 32'(65536 - tally));
		tally = 0;
		// a take at zero must not wrap below zero
		take();
		for (i = 1; i < 4; i++)
		begin
			wr(8'h00, 32'h1);
			tally = tally + 1;
			repeat (3) @(posedge clk_sys);
			#1;
			chk(32'(free_buffer_tally), 32'(tally));
			chk(32'(rx_buffers_short), 32'(tally < 3));
		end
		take();
		tally = tally - 1;
		for (i = 1; i < 5; i++)
		begin
			v = $random(seed);
			a = 32'(i * 4);
			m = (i == 3) ? 32'hfffffffe : 32'hfffffffd;
			m = (i == 4) ? 32'hffffffff : m;
			wr(a[7:0], v);
			rd(a[7:0], v & m);
			wr(a[7:0], 32'h0);
		end
		wr(8'h14, 32'hffffffff);
		rd(8'h14, 32'h0);
		rd(8'h00, 32'(tally));
		// a write while the clock enable is low must not land
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(8'h00, 32'h5);
		ce <= 1'b1;
		rd(8'h00, 32'(tally));
		chk(32'(free_buffer_tally), 32'(tally));
		a = $random(seed);
		b = $random(seed);
		p.ld(a, b, 1'b1, 1'b0, 0);
		p.ev(1'b1, 1'b0, 1'b0, 16'h0004, 32'h0);
		p.ev(1'b1, 1'b1, 1'b0, 16'h01fc, 32'h0);
		rd(8'h04, 32'h1);
		rd(8'h08, a & 32'hfffffffc | 32'h1);
		rd(8'h0c, a & 32'hfffffffc | 32'h2);
		rd(8'h10, b + 32'h200);
		chk(active_descriptor_pointer, a & 32'hfffffffc);
		chk(active_buffer_byte_address, b + 32'h200);
		chk(32'(tx_in_packet), 32'h1);
		chk(32'(tx_early_truncation), 32'h1);
		v = $random(seed);
		m = $random(seed);
		p.ld(v, b, 1'b0, 1'b1, 3);
		rd(8'h0c, v & 32'hfffffffc | 32'h2);
		p.ev(1'b0, 1'b0, 1'b1, 16'h0, m);
		rd(8'h04, m & 32'hfffffffc);
		rd(8'h08, a & 32'hfffffffc);
		rd(8'h0c, v & 32'hfffffffc);
		chk(32'(tx_in_packet), 32'h0);
		chk(32'(tx_early_truncation), 32'h0);
		p.ev(1'b0, 1'b0, 1'b1, 16'h0, ~m);
		rd(8'h04, m & 32'hfffffffc);
		p.ld(b, a, 1'b1, 1'b1, 0);
		p.ev(1'b0, 1'b1, 1'b0, 16'h0, 32'h0);
		rd(8'h0c, b & 32'hfffffffc);
		chk(32'(tx_early_truncation), 32'h0);
		test_done();
	end
endmodule

`default_nettype wire
